/* File: fpc_pin_ctrl.sv */
// The register offsets and strobed register access were left to the implementer.
module fpc_pin_ctrl #(
  parameter bit HAS_DEDICATED_RESET = 1'b1
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  input  wire logic [fpc_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [fpc_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [fpc_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic                        core_busy,
  input  wire logic                        link_clk,
  input  wire logic                        cs_n,
  input  wire logic                        si_in,
  input  wire logic                        so_in,
  output logic                             so_out,
  output logic                             so_oe,
  input  wire logic                        io2_in,
  output logic                             io2_out,
  output logic                             io2_oe,
  input  wire logic                        io3_in,
  output logic                             io3_out,
  output logic                             io3_oe,
  input  wire logic                        rst_pin_n
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0]          status_reg;
  logic [7:0]          status_next;
  logic                fsel_reg;
  logic                ddis_reg;
  logic                outdir_reg;
  logic [7:0]          rxdata_reg;
  logic [7:0]          rdata_reg;
  logic [1:0]          wp_sync_reg;
  logic [1:0]          pause_sync_reg;
  logic [1:0]          rst_sync_reg;
  logic [2:0]          tgl_sync_reg;
  logic [7:0]          link_byte_reg;
  logic                link_tgl_reg;
  logic                link_pause;
  logic                link_rst;

  wire wp_level    = wp_sync_reg[1];
  wire wr_status   = reg_wr && (reg_addr == fpc_pkg::STATUS_OFS);
  // Write-protect pin only counts while it is not a data line
  wire sr_locked   = status_reg[fpc_pkg::SWD_BIT] && !wp_level
                     && !status_reg[fpc_pkg::QE_BIT];
  wire byte_evt    = tgl_sync_reg[2] ^ tgl_sync_reg[1];

  // Locked write keeps bits 7..2 whole, only the latch bit moves
  assign status_next = sr_locked
    ? {status_reg[7:2], reg_wdata[fpc_pkg::WEL_BIT], 1'b0}
    : {reg_wdata[7:2], reg_wdata[fpc_pkg::WEL_BIT], 1'b0};

  wire [7:0] pinstat = {5'h00, rst_sync_reg[1], pause_sync_reg[1], wp_level};
  wire [7:0] status_view = {status_reg[7:1], core_busy};
  wire [7:0] rd_mux =
      (reg_addr == fpc_pkg::STATUS_OFS)  ? status_view :
      (reg_addr == fpc_pkg::READ_OFS)    ? {fsel_reg, 7'h00} :
      (reg_addr == fpc_pkg::FUNC_OFS)    ? {7'h00, ddis_reg} :
      (reg_addr == fpc_pkg::CTRL_OFS)    ? {7'h00, outdir_reg} :
      (reg_addr == fpc_pkg::PINSTAT_OFS) ? pinstat :
      (reg_addr == fpc_pkg::RXDATA_OFS)  ? rxdata_reg : 8'h00;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      status_reg <= fpc_pkg::STATUS_RST;
      fsel_reg   <= fpc_pkg::FSEL_RST;
      ddis_reg   <= fpc_pkg::DDIS_RST;
      outdir_reg <= fpc_pkg::OUTDIR_RST;
    end else begin
      if (wr_status) begin
        status_reg <= status_next;
      end
      if (reg_wr && reg_addr == fpc_pkg::READ_OFS) begin
        fsel_reg <= reg_wdata[fpc_pkg::FSEL_BIT];
      end
      if (reg_wr && reg_addr == fpc_pkg::FUNC_OFS) begin
        ddis_reg <= reg_wdata[fpc_pkg::DDIS_BIT];
      end
      if (reg_wr && reg_addr == fpc_pkg::CTRL_OFS) begin
        outdir_reg <= reg_wdata[fpc_pkg::OUTDIR_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;

  // ****************************************************************
  // Crossings into the register clock
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wp_sync_reg    <= 2'h0;
      pause_sync_reg <= 2'h0;
      rst_sync_reg   <= 2'h0;
      tgl_sync_reg   <= 3'h0;
      rxdata_reg     <= fpc_pkg::BYTE_RST;
    end else begin
      wp_sync_reg    <= {wp_sync_reg[0], io2_in};
      pause_sync_reg <= {pause_sync_reg[0], link_pause};
      rst_sync_reg   <= {rst_sync_reg[0], link_rst};
      tgl_sync_reg   <= {tgl_sync_reg[1:0], link_tgl_reg};
      if (byte_evt) begin
        rxdata_reg <= link_byte_reg;
      end
    end
  end

  // ****************************************************************
  // Pin function decode, link clock
  // ****************************************************************
  fpc_pkg::fpc_cfg_type cfg_meta_reg;
  fpc_pkg::fpc_cfg_type cfg_reg;
  fpc_pkg::fpc_link_state_type lk_state_reg;
  fpc_pkg::fpc_link_state_type lk_state_next;
  logic [2:0]          bit_cnt_reg;
  logic [2:0]          bit_cnt_next;
  logic [7:0]          shift_reg;
  logic [7:0]          shift_next;
  logic [7:0]          tx_reg;
  logic                so_reg;
  logic                byte_done;

  wire fpc_pkg::fpc_cfg_type cfg_src = '{
    quad_line_enable:        status_reg[fpc_pkg::QE_BIT],
    pin_function_select_bit: fsel_reg,
    dedicated_reset_disable: ddis_reg,
    out_dir:                 outdir_reg
  };

  wire quad      = cfg_reg.quad_line_enable;
  wire ded_on    = HAS_DEDICATED_RESET && !cfg_reg.dedicated_reset_disable;
  // Shared pin role: nothing in quad mode, else pause or reset
  wire sh_reset  = !quad && !ded_on && cfg_reg.pin_function_select_bit;
  wire sh_pause  = !quad && !sh_reset;
  wire pause_act = sh_pause && !io3_in && !cs_n;
  wire reset_act = (ded_on && !rst_pin_n) || (sh_reset && !io3_in);
  wire frame_rst_n = rstn && !cs_n;

  assign link_pause = pause_act;
  assign link_rst   = reset_act;

  assign lk_state_next = reset_act ? fpc_pkg::LK_RESET :
                         pause_act ? fpc_pkg::LK_PAUSE : fpc_pkg::LK_SHIFT;
  wire shifting     = (lk_state_next == fpc_pkg::LK_SHIFT);
  // Pause freezes counter and shifter, so the sequence survives
  assign shift_next = !shifting ? shift_reg :
                      quad ? {shift_reg[3:0], io3_in, io2_in, so_in, si_in} :
                             {shift_reg[6:0], si_in};
  assign bit_cnt_next = reset_act ? fpc_pkg::CNT_RST :
                        !shifting ? bit_cnt_reg :
                        quad      ? bit_cnt_reg + 3'h4 : bit_cnt_reg + 3'h1;
  assign byte_done = shifting && (bit_cnt_next == fpc_pkg::CNT_RST);

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_meta_reg <= '0;
      cfg_reg      <= '0;
    end else begin
      cfg_meta_reg <= cfg_src;
      cfg_reg      <= cfg_meta_reg;
    end
  end

  always_ff @(posedge link_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      lk_state_reg <= fpc_pkg::LK_IDLE;
      bit_cnt_reg  <= fpc_pkg::CNT_RST;
      shift_reg    <= fpc_pkg::BYTE_RST;
    end else begin
      lk_state_reg <= lk_state_next;
      bit_cnt_reg  <= bit_cnt_next;
      shift_reg    <= shift_next;
    end
  end

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      link_byte_reg <= fpc_pkg::BYTE_RST;
      link_tgl_reg  <= 1'b0;
      tx_reg        <= fpc_pkg::BYTE_RST;
    end else if (byte_done) begin
      link_byte_reg <= shift_next;
      link_tgl_reg  <= !link_tgl_reg;
      tx_reg        <= shift_next;
    end
  end

  // Output data on so_out changes on the falling edge; io2_out and io3_out change after the rising edge
  always_ff @(negedge link_clk or negedge rstn) begin
    if (!rstn) begin
      so_reg <= 1'b0;
    end else begin
      so_reg <= tx_reg[~bit_cnt_reg];
    end
  end

  assign so_out  = so_reg;
  assign io2_out = tx_reg[{1'b1, bit_cnt_reg[2], 1'b0}];
  assign io3_out = tx_reg[{1'b1, bit_cnt_reg[2], 1'b1}];
  assign so_oe   = !cs_n && !pause_act && !reset_act && cfg_reg.out_dir;
  assign io2_oe  = !cs_n && quad && !reset_act && cfg_reg.out_dir;
  assign io3_oe  = !cs_n && quad && !reset_act && cfg_reg.out_dir;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_locked_write;
    wr_status && sr_locked;
  endsequence

  sequence s_open_write;
    wr_status && !status_reg[fpc_pkg::SWD_BIT];
  endsequence

  a_locked_keep: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    s_locked_write |=> status_reg[7:2] == $past(status_reg[7:2]))
    else $error("locked status write changed protected bits");

  a_open_write: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    s_open_write |=> status_reg[7:2] == $past(reg_wdata[7:2]))
    else $error("unprotected status write not stored");

  a_quad_no_lock: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    wr_status && status_reg[fpc_pkg::QE_BIT] |=> status_reg[7:2] == $past(reg_wdata[7:2]))
    else $error("write refused while in quad mode");

  a_wp_high_open: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    wr_status && wp_level |=> status_reg[7:2] == $past(reg_wdata[7:2]))
    else $error("write refused with protect pin high");

  a_quad_no_pause: assert property (
    @(posedge link_clk) disable iff (!rstn)
    quad |-> !sh_pause && !sh_reset && !pause_act)
    else $error("shared pin function active in quad mode");

  a_ded_pause: assert property (
    @(posedge link_clk) disable iff (!rstn)
    !quad && ded_on |-> sh_pause && !sh_reset)
    else $error("shared pin not pause with dedicated reset on");

  a_sel_reset: assert property (
    @(posedge link_clk) disable iff (!rstn)
    !quad && !ded_on |-> sh_reset == cfg_reg.pin_function_select_bit)
    else $error("shared pin ignores select bit");

  a_pause_hiz: assert property (
    @(posedge link_clk) disable iff (!rstn)
    sh_pause && !io3_in && !cs_n |-> !so_oe)
    else $error("serial output driven during pause");

  a_pause_hold: assert property (
    @(posedge link_clk) disable iff (!frame_rst_n)
    pause_act && !reset_act |=> bit_cnt_reg == $past(bit_cnt_reg)
                                && shift_reg == $past(shift_reg))
    else $error("sequence changed during pause");

  a_nodedic_sel: assert property (
    @(posedge link_clk) disable iff (!rstn)
    !HAS_DEDICATED_RESET && !quad |-> sh_reset == cfg_reg.pin_function_select_bit)
    else $error("shared pin ignores select bit without dedicated reset");

  a_resume_shift: assert property (
    @(posedge link_clk) disable iff (!frame_rst_n)
    shifting && !quad |=> bit_cnt_reg == 3'($past(bit_cnt_reg) + 3'h1))
    else $error("transfer did not resume after pause");

  a_reset_hiz: assert property (
    @(posedge link_clk) disable iff (!rstn)
    reset_act |-> !so_oe && !io2_oe && !io3_oe)
    else $error("outputs driven during reset");

endmodule

/* File: fpc_pkg.sv */
package fpc_pkg;

  // ****************************************************************
  // Register port
  // ****************************************************************
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  localparam logic [3:0] STATUS_OFS  = 4'h0;
  localparam logic [3:0] READ_OFS    = 4'h1;
  localparam logic [3:0] FUNC_OFS    = 4'h2;
  localparam logic [3:0] CTRL_OFS    = 4'h3;
  localparam logic [3:0] PINSTAT_OFS = 4'h4;
  localparam logic [3:0] RXDATA_OFS  = 4'h5;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned SWD_BIT    = 7;
  localparam int unsigned QE_BIT     = 6;
  localparam int unsigned BP_HI      = 5;
  localparam int unsigned BP_LO      = 2;
  localparam int unsigned WEL_BIT    = 1;
  localparam int unsigned BUSY_BIT   = 0;
  localparam int unsigned FSEL_BIT   = 7;
  localparam int unsigned DDIS_BIT   = 0;
  localparam int unsigned OUTDIR_BIT = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic       FSEL_RST   = 1'b0;
  localparam logic       DDIS_RST   = 1'b0;
  localparam logic       OUTDIR_RST = 1'b0;
  localparam logic [2:0] CNT_RST    = 3'h0;
  localparam logic [7:0] BYTE_RST   = 8'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic quad_line_enable;
    logic pin_function_select_bit;
    logic dedicated_reset_disable;
    logic out_dir;
  } fpc_cfg_type;

  typedef enum logic [3:0] {
    LK_IDLE  = 4'h1,
    LK_SHIFT = 4'h2,
    LK_PAUSE = 4'h4,
    LK_RESET = 4'h8
  } fpc_link_state_type;

endpackage

/* File: fpc_link_master.sv */
module fpc_link_master (
  output logic       link_clk,
  output logic       cs_n,
  output logic       rst_n,
  output logic [3:0] d_out,
  output logic [3:0] d_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // Serial master
  // ****
  logic wp_lvl;
  logic hold_lvl;
  initial begin
    link_clk = 1'b0;
    cs_n = 1'b1;
    rst_n = 1'b1;
    wp_lvl = 1'b0;
    hold_lvl = 1'b1;
    d_out = 4'h9;
    d_oe = 4'hD;
  end
  task set_pins(input logic wp, input logic hold);
    wp_lvl = wp;
    hold_lvl = hold;
    d_out[3:2] = {hold, wp};
  endtask
  task set_reset(input logic lvl);
    rst_n = lvl;
  endtask
  task pulse();
    #62.5 link_clk = 1'b1;
    #62.5 link_clk = 1'b0;
  endtask
  task start();
    repeat (2) pulse();
    #20 cs_n = 1'b0;
  endtask
  task bits(input logic [7:0] b, input int n, input bit quad);
    for (int i = 0; i < n; i++) begin
      if (quad) begin
        d_oe = 4'hF;
        d_out = (i == 0) ? b[7:4] : b[3:0];
      end else begin
        d_out[0] = b[7-i];
      end
      pulse();
    end
  endtask
  task stop();
    #62.5 cs_n = 1'b1;
    d_oe = 4'hD;
    d_out = {hold_lvl, wp_lvl, ~d_out[1], ~d_out[0]};
  endtask
endmodule

/* File: fpc_pin_ctrl_test.sv */
module fpc_pin_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // Bench
  // ****
  logic       sys_clk;
  logic       rstn;
  logic       reg_wr;
  logic       reg_rd;
  logic       core_busy;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       so_out;
  logic       so_oe;
  logic       io2_out;
  logic       io2_oe;
  logic       io3_out;
  logic       io3_oe;
  wire        link_clk;
  wire        cs_n;
  wire        rst_pin_n;
  wire  [3:0] m_out;
  wire  [3:0] m_oe;
  wire        so_w  = so_oe ? so_out : (m_oe[1] ? m_out[1] : ~so_out);
  wire        io2_w = io2_oe ? io2_out : m_out[2];
  wire        io3_w = io3_oe ? io3_out : m_out[3];
  int         n_fail;
  int         tests_run;

  fpc_pin_ctrl dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .core_busy(core_busy), .link_clk(link_clk), .cs_n(cs_n), .si_in(m_out[0]),
    .so_in(so_w), .so_out(so_out), .so_oe(so_oe), .io2_in(io2_w), .io2_out(io2_out),
    .io2_oe(io2_oe), .io3_in(io3_w), .io3_out(io3_out), .io3_oe(io3_oe),
    .rst_pin_n(rst_pin_n));
  fpc_link_master m (.link_clk(link_clk), .cs_n(cs_n), .rst_n(rst_pin_n),
    .d_out(m_out), .d_oe(m_oe));

  always #5 sys_clk = ~sys_clk;

  task check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rdchk(input logic [3:0] a, input logic [7:0] e, input logic [7:0] msk);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata & msk, e);
  endtask
  task report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #200us;
    n_fail++;
    report_and_stop();
  end

  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    core_busy = 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    rdchk(fpc_pkg::STATUS_OFS, 8'h00, 8'hFF);
    rdchk(fpc_pkg::FUNC_OFS, 8'h00, 8'hFF);
    rdchk(fpc_pkg::READ_OFS, 8'h00, 8'hFF);
    $display("test reset done");
    wr(fpc_pkg::STATUS_OFS, 8'hBC);
    rdchk(fpc_pkg::STATUS_OFS, 8'hBC, 8'hFF);
    wr(fpc_pkg::STATUS_OFS, 8'h42);
    rdchk(fpc_pkg::STATUS_OFS, 8'hBE, 8'hFF);
    wr(4'hF, 8'hFF);
    rdchk(4'hF, 8'h00, 8'hFF);
    m.set_pins(1'b1, 1'b1);
    repeat (4) @(posedge sys_clk);
    wr(fpc_pkg::STATUS_OFS, 8'h80);
    rdchk(fpc_pkg::STATUS_OFS, 8'h80, 8'hFF);
    $display("test protect done");
    wr(fpc_pkg::CTRL_OFS, 8'h01);
    m.start();
    m.bits(8'hA5, 4, 1'b0);
    m.set_pins(1'b1, 1'b0);
    repeat (2) @(posedge sys_clk);
    rdchk(fpc_pkg::PINSTAT_OFS, 8'h02, 8'h06);
    check({7'h00, so_oe}, 8'h00);
    m.bits(8'hFF, 3, 1'b0);
    m.set_pins(1'b1, 1'b1);
    m.bits(8'h50, 4, 1'b0);
    m.stop();
    repeat (8) @(posedge sys_clk);
    rdchk(fpc_pkg::RXDATA_OFS, 8'hA5, 8'hFF);
    $display("test pause done");
    wr(fpc_pkg::READ_OFS, 8'h80);
    m.start();
    m.set_pins(1'b1, 1'b0);
    repeat (2) @(posedge sys_clk);
    rdchk(fpc_pkg::PINSTAT_OFS, 8'h02, 8'h06);
    m.stop();
    wr(fpc_pkg::FUNC_OFS, 8'h01);
    m.start();
    repeat (4) @(posedge sys_clk);
    rdchk(fpc_pkg::PINSTAT_OFS, 8'h04, 8'h06);
    m.stop();
    wr(fpc_pkg::FUNC_OFS, 8'h00);
    m.set_pins(1'b1, 1'b1);
    m.set_reset(1'b0);
    m.start();
    repeat (4) @(posedge sys_clk);
    rdchk(fpc_pkg::PINSTAT_OFS, 8'h04, 8'h06);
    m.bits(8'h3C, 8, 1'b0);
    check({5'h00, so_oe, io2_oe, io3_oe}, 8'h00);
    m.stop();
    repeat (8) @(posedge sys_clk);
    rdchk(fpc_pkg::RXDATA_OFS, 8'hA5, 8'hFF);
    m.set_reset(1'b1);
    $display("test function done");
    wr(fpc_pkg::CTRL_OFS, 8'h00);
    wr(fpc_pkg::STATUS_OFS, 8'hC0);
    m.set_pins(1'b0, 1'b0);
    m.start();
    repeat (4) @(posedge sys_clk);
    rdchk(fpc_pkg::PINSTAT_OFS, 8'h00, 8'h06);
    wr(fpc_pkg::STATUS_OFS, 8'hC4);
    rdchk(fpc_pkg::STATUS_OFS, 8'hC4, 8'hFF);
    m.bits(8'h69, 2, 1'b1);
    m.stop();
    repeat (8) @(posedge sys_clk);
    rdchk(fpc_pkg::RXDATA_OFS, 8'h69, 8'hFF);
    m.set_pins(1'b1, 1'b1);
    wr(fpc_pkg::STATUS_OFS, 8'h00);
    core_busy <= 1'b1;
    rdchk(fpc_pkg::STATUS_OFS, 8'h01, 8'hFF);
    $display("test quad done");
    report_and_stop();
  end
endmodule
